// ### pkg/cmov_pkg.sv
// Constants for the conditional move decoder and its register file
`default_nettype none
package cmov_pkg;
	localparam int DATA_W = 32;
	localparam int REG_AW = 3;
	localparam logic [7:0] OPC_ESCAPE = 8'h0F;
	localparam logic [7:0] OPC_MOVE_IF_BELOW = 8'h42;
	localparam logic [7:0] OPC_MOVE_IF_ABOVE_OR_EQUAL = 8'h43;
	localparam logic [7:0] OPC_MOVE_IF_EQUAL = 8'h44;
	localparam logic [7:0] OPC_MOVE_IF_NOT_EQUAL = 8'h45;
	localparam logic [7:0] OPC_MOVE_IF_BELOW_OR_EQUAL = 8'h46;
	localparam logic [7:0] OPC_MOVE_IF_ABOVE = 8'h47;
	localparam logic [7:0] OPC_MOVE_IF_GREATER = 8'h4F;
	// Operand byte layout: mod[7:6] reg[5:3] r/m[2:0]
	localparam int MODRM_MOD_LSB = 6;
	localparam int MODRM_REG_LSB = 3;
	localparam int MODRM_RM_LSB = 0;
	localparam logic [1:0] MOD_REGISTER = 2'b11;
	// Status flag positions in the flags word
	localparam int FLAG_CF = 0;
	localparam int FLAG_ZF = 6;
	localparam int FLAG_SF = 7;
	localparam int FLAG_OF = 11;
	localparam logic [DATA_W-1:0] FLAGS_RESET = 32'h0000_0002;
	localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000;
	typedef enum logic {ST_IDLE, ST_EXEC} stage_t;
endpackage
`default_nettype wire

// ### rtl/gpr_file.sv
// General register file: one write port, two registered read ports
`default_nettype none
module gpr_file #(
	parameter int AW = 3,
	parameter int DW = 32
) (
	input wire logic mclk_i,
	input wire logic we_i,
	input wire logic [AW-1:0] wa_i,
	input wire logic [DW-1:0] wd_i,
	input wire logic [AW-1:0] ra_a_i,
	output logic [DW-1:0] rd_a_o,
	input wire logic [AW-1:0] ra_b_i,
	output logic [DW-1:0] rd_b_o
);
	logic [DW-1:0] mem [2**AW];

	// Read returns the old word when read and write hit the same entry
	always_ff @(posedge mclk_i) begin
		if (we_i) begin
			mem[wa_i] <= wd_i;
		end
		rd_a_o <= mem[ra_a_i];
		rd_b_o <= mem[ra_b_i];
	end
endmodule
`default_nettype wire

// ### rtl/conditional_move_decoder.sv
// Decode and execute of the conditional move group
// Function
// - Opcode 0F 47 with an operand byte is move_if_above and moves only when CF and ZF are clear.
// - Opcode 0F 46 is move_if_below_or_equal and moves only when CF or ZF is set.
// - Opcode 0F 43 is move_if_above_or_equal and moves only when CF is clear.
// - Opcode 0F 42 is move_if_below and moves only when CF is set.
// - Opcode 0F 44 is move_if_equal and moves only when ZF is set.
// - Opcode 0F 45 is move_if_not_equal and moves only when ZF is clear.
// - Opcode 0F 4F is move_if_greater and moves only when ZF is clear and SF equals OF.
`default_nettype none
module conditional_move_decoder
	import cmov_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic req_valid_i,
	input wire logic [7:0] op_esc_i,
	input wire logic [7:0] op_code_i,
	input wire logic [7:0] modrm_i,
	input wire logic [cmov_pkg::DATA_W-1:0] mem_data_i,
	input wire logic [cmov_pkg::DATA_W-1:0] flags_i,
	input wire logic [cmov_pkg::REG_AW-1:0] dbg_idx_i,
	output logic done_o,
	output logic taken_o,
	output logic illegal_o,
	output logic [cmov_pkg::REG_AW-1:0] dst_idx_o,
	output logic [cmov_pkg::DATA_W-1:0] flags_o,
	output logic wr_en_o,
	output logic [cmov_pkg::REG_AW-1:0] wr_idx_o,
	output logic [cmov_pkg::DATA_W-1:0] wr_data_o,
	output logic [cmov_pkg::DATA_W-1:0] dbg_data_o
);
	import cmov_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	function automatic logic is_cmov(input logic [7:0] esc, input logic [7:0] op);
		logic hit;
		hit = 1'b0;
		if (esc == OPC_ESCAPE) begin
			unique case (op)
				OPC_MOVE_IF_ABOVE, OPC_MOVE_IF_BELOW_OR_EQUAL,
				OPC_MOVE_IF_ABOVE_OR_EQUAL, OPC_MOVE_IF_BELOW,
				OPC_MOVE_IF_EQUAL, OPC_MOVE_IF_NOT_EQUAL,
				OPC_MOVE_IF_GREATER: hit = 1'b1;
				default: hit = 1'b0;
			endcase
		end
		return hit;
	endfunction

	function automatic logic cond_met(input logic [7:0] op, input logic [DATA_W-1:0] f);
		logic c;
		c = 1'b0;
		unique case (op)
			OPC_MOVE_IF_ABOVE: c = !f[FLAG_CF] && !f[FLAG_ZF];
			OPC_MOVE_IF_BELOW_OR_EQUAL: c = f[FLAG_CF] || f[FLAG_ZF];
			OPC_MOVE_IF_ABOVE_OR_EQUAL: c = !f[FLAG_CF];
			OPC_MOVE_IF_BELOW: c = f[FLAG_CF];
			OPC_MOVE_IF_EQUAL: c = f[FLAG_ZF];
			OPC_MOVE_IF_NOT_EQUAL: c = !f[FLAG_ZF];
			OPC_MOVE_IF_GREATER: c = !f[FLAG_ZF] && (f[FLAG_SF] == f[FLAG_OF]);
			default: c = 1'b0;
		endcase
		return c;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Execute stage: one cycle after issue, taken or not
	stage_t st_q, st_d;
	logic taken_q, taken_d, illegal_q, illegal_d, use_mem_q, use_mem_d;
	logic [REG_AW-1:0] dst_q, dst_d, src_q, src_d;
	logic [DATA_W-1:0] mem_q, mem_d, flags_q, flags_d;
	logic recognised;

	always_comb begin
		recognised = is_cmov(op_esc_i, op_code_i);
		st_d = req_valid_i ? ST_EXEC : ST_IDLE;
		taken_d = req_valid_i && recognised && cond_met(op_code_i, flags_i);
		illegal_d = req_valid_i && !recognised;
		dst_d = req_valid_i ? modrm_i[MODRM_REG_LSB+:REG_AW] : dst_q;
		src_d = req_valid_i ? modrm_i[MODRM_RM_LSB+:REG_AW] : src_q;
		use_mem_d = req_valid_i ? (modrm_i[MODRM_MOD_LSB+:2] != MOD_REGISTER) : use_mem_q;
		mem_d = req_valid_i ? mem_data_i : mem_q;
		// Flags are only carried along, never produced here
		flags_d = req_valid_i ? flags_i : flags_q;
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			st_q <= ST_IDLE;
			taken_q <= 1'b0;
			illegal_q <= 1'b0;
			use_mem_q <= 1'b0;
			dst_q <= '0;
			src_q <= '0;
			mem_q <= DATA_RESET;
			flags_q <= FLAGS_RESET;
		end else begin
			st_q <= st_d;
			taken_q <= taken_d;
			illegal_q <= illegal_d;
			use_mem_q <= use_mem_d;
			dst_q <= dst_d;
			src_q <= src_d;
			mem_q <= mem_d;
			flags_q <= flags_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register write-back, one edge after the execute cycle
	logic wr_en_q, wr_en_d;
	logic [REG_AW-1:0] wr_idx_q, wr_idx_d;
	logic [DATA_W-1:0] wr_data_q, wr_data_d, rf_rd, src_val;

	always_comb begin
		// The file reads the old word when the previous move writes the
		// same register on that edge, so the last write is forwarded
		if (!use_mem_q && wr_en_q && (wr_idx_q == src_q)) begin
			src_val = wr_data_q;
		end else if (use_mem_q) begin
			src_val = mem_q;
		end else begin
			src_val = rf_rd;
		end
		wr_en_d = (st_q == ST_EXEC) && taken_q;
		wr_idx_d = dst_q;
		wr_data_d = src_val;
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_en_q <= 1'b0;
			wr_idx_q <= '0;
			wr_data_q <= DATA_RESET;
		end else begin
			wr_en_q <= wr_en_d;
			wr_idx_q <= wr_idx_d;
			wr_data_q <= wr_data_d;
		end
	end

	gpr_file #(
		.AW(REG_AW),
		.DW(DATA_W)
	) u_gpr (
		.mclk_i(mclk_i),
		.we_i(wr_en_d),
		.wa_i(wr_idx_d),
		.wd_i(wr_data_d),
		.ra_a_i(modrm_i[MODRM_RM_LSB+:REG_AW]),
		.rd_a_o(rf_rd),
		.ra_b_i(dbg_idx_i),
		.rd_b_o(dbg_data_o)
	);

	assign done_o = (st_q == ST_EXEC);
	assign taken_o = taken_q;
	assign illegal_o = illegal_q;
	assign dst_idx_o = dst_q;
	assign flags_o = flags_q;
	assign wr_en_o = wr_en_q;
	assign wr_idx_o = wr_idx_q;
	assign wr_data_o = wr_data_q;

	////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	logic is_esc;
	assign is_esc = req_valid_i && (op_esc_i == OPC_ESCAPE);

	sequence s_issue;
		req_valid_i;
	endsequence
	sequence s_complete;
		done_o && (flags_o == $past(flags_i));
	endsequence
	sequence s_taken_write;
		(done_o && taken_o) ##1 wr_en_o;
	endsequence
	// Register source written by the move just before, so only forwarding gives the new word
	sequence s_dependent;
		done_o && taken_o && wr_en_o && !use_mem_q && (src_q == wr_idx_o);
	endsequence

	AST_ABOVE: assert property (is_esc && op_code_i == OPC_MOVE_IF_ABOVE
		|=> taken_o == $past(!flags_i[FLAG_CF] && !flags_i[FLAG_ZF]))
		else $error("above condition mismatch");
	AST_BELOW_OR_EQUAL: assert property (is_esc && op_code_i == OPC_MOVE_IF_BELOW_OR_EQUAL
		|=> taken_o == $past(flags_i[FLAG_CF] || flags_i[FLAG_ZF]))
		else $error("below-or-equal condition mismatch");
	AST_ABOVE_OR_EQUAL: assert property (is_esc && op_code_i == OPC_MOVE_IF_ABOVE_OR_EQUAL
		|=> taken_o != $past(flags_i[FLAG_CF]))
		else $error("above-or-equal condition mismatch");
	AST_BELOW: assert property (is_esc && op_code_i == OPC_MOVE_IF_BELOW
		&& flags_i[FLAG_CF] |=> taken_o && !illegal_o ##1 wr_en_o)
		else $error("below move not written");
	AST_EQUAL: assert property (is_esc && op_code_i == OPC_MOVE_IF_EQUAL
		&& !flags_i[FLAG_ZF] |=> !taken_o ##1 !wr_en_o)
		else $error("equal move written while zero clear");
	AST_NOT_EQUAL: assert property (is_esc && op_code_i == OPC_MOVE_IF_NOT_EQUAL
		|=> taken_o == !$past(flags_i[FLAG_ZF]))
		else $error("not-equal condition mismatch");
	AST_GREATER: assert property (is_esc && op_code_i == OPC_MOVE_IF_GREATER
		|=> taken_o == $past(!flags_i[FLAG_ZF] && (flags_i[FLAG_SF] == flags_i[FLAG_OF])))
		else $error("greater condition mismatch");
	AST_ONE_CLOCK: assert property (s_issue |=> s_complete)
		else $error("move did not complete in one clock with flags kept");
	AST_WRITE_BACK: assert property (s_taken_write |-> wr_idx_o == $past(dst_idx_o))
		else $error("write-back went to the wrong register");
	AST_MEM_SOURCE: assert property (req_valid_i && modrm_i[MODRM_MOD_LSB+:2] != MOD_REGISTER
		|=> taken_o |=> wr_en_o && wr_data_o == $past(mem_data_i, 2))
		else $error("memory source not moved");
	AST_NO_WRITE_REFUSED: assert property (done_o && !taken_o |=> !wr_en_o)
		else $error("refused move wrote a register");
	AST_FORWARD: assert property (s_dependent |=> wr_data_o == $past(wr_data_o))
		else $error("dependent register source not forwarded");
endmodule
`default_nettype wire

// ### tb/conditional_move_decoder_tb.sv
// Self-checking bench for the conditional move decoder
`default_nettype none
module conditional_move_decoder_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import cmov_pkg::*;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic req_valid_i = 1'b0;
	logic [7:0] op_esc_i = 8'h00;
	logic [7:0] op_code_i = 8'h00;
	logic [7:0] modrm_i = 8'h00;
	logic [31:0] mem_data_i = 32'h0000_0000;
	logic [31:0] flags_i = 32'h0000_0000;
	logic [2:0] dbg_idx_i = 3'h0;
	logic done_o, taken_o, illegal_o, wr_en_o;
	logic [2:0] dst_idx_o, wr_idx_o;
	logic [31:0] flags_o, wr_data_o, dbg_data_o;
	int errors = 0;
	int total_checks = 0;

	conditional_move_decoder dut (.mclk_i(mclk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
		.op_esc_i(op_esc_i), .op_code_i(op_code_i), .modrm_i(modrm_i),
		.mem_data_i(mem_data_i), .flags_i(flags_i), .dbg_idx_i(dbg_idx_i), .done_o(done_o),
		.taken_o(taken_o), .illegal_o(illegal_o), .dst_idx_o(dst_idx_o), .flags_o(flags_o),
		.wr_en_o(wr_en_o), .wr_idx_o(wr_idx_o), .wr_data_o(wr_data_o), .dbg_data_o(dbg_data_o));

	initial begin
		forever #20 mclk_i = ~mclk_i;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic close_out();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Flag nibble f is {OF, SF, ZF, CF}
	function automatic logic cond(input logic [7:0] opc, input logic [3:0] f);
		case (opc)
			OPC_MOVE_IF_ABOVE: return !f[0] && !f[1];
			OPC_MOVE_IF_BELOW_OR_EQUAL: return f[0] || f[1];
			OPC_MOVE_IF_ABOVE_OR_EQUAL: return !f[0];
			OPC_MOVE_IF_BELOW: return f[0];
			OPC_MOVE_IF_EQUAL: return f[1];
			OPC_MOVE_IF_NOT_EQUAL: return !f[1];
			OPC_MOVE_IF_GREATER: return !f[1] && (f[2] == f[3]);
			default: return 1'b0;
		endcase
	endfunction

	// One issue, then the completion and write-back cycles
	task automatic run_op(input logic [7:0] esc, input logic [7:0] opc, input logic [3:0] f,
			input logic [7:0] modrm, input logic [31:0] mem, input logic tk, input logic ill,
			input logic [31:0] data);
		logic [31:0] fw;
		fw = ~FLAGS_RESET;
		fw[FLAG_CF] = f[0];
		fw[FLAG_ZF] = f[1];
		fw[FLAG_SF] = f[2];
		fw[FLAG_OF] = f[3];
		req_valid_i = 1'b1;
		op_esc_i = esc;
		op_code_i = opc;
		modrm_i = modrm;
		mem_data_i = mem;
		flags_i = fw;
		@(negedge mclk_i);
		req_valid_i = 1'b0;
		check("done", 32'(done_o), 32'h0000_0001);
		check("taken", 32'(taken_o), 32'(tk));
		check("illegal", 32'(illegal_o), 32'(ill));
		check("flags", flags_o, fw);
		check("dst", 32'(dst_idx_o), 32'(modrm[5:3]));
		@(negedge mclk_i);
		check("wr_en", 32'(wr_en_o), 32'(tk));
		if (tk) begin
			check("wr_idx", 32'(wr_idx_o), 32'(modrm[5:3]));
			check("wr_data", wr_data_o, data);
		end
	endtask

	// All sixteen flag mixes against one opcode, memory source
	task automatic sweep(input logic [7:0] opc);
		logic [31:0] mem;
		for (int i = 0; i < 16; i++) begin
			mem = {16'h5A5A, opc, 8'(i)};
			run_op(OPC_ESCAPE, opc, 4'(i), {2'b00, 3'(i), 3'b000}, mem, cond(opc, 4'(i)),
				1'b0, mem);
		end
	endtask

	// Register source, then a refused move must not disturb the target
	task automatic reg_source();
		run_op(OPC_ESCAPE, OPC_MOVE_IF_EQUAL, 4'h2, 8'h08, 32'hA5A5_0001, 1'b1, 1'b0,
			32'hA5A5_0001);
		run_op(OPC_ESCAPE, OPC_MOVE_IF_BELOW, 4'h1, 8'hD1, 32'h0000_0000, 1'b1, 1'b0,
			32'hA5A5_0001);
		run_op(OPC_ESCAPE, OPC_MOVE_IF_BELOW, 4'h0, 8'h10, 32'hFFFF_FFFF, 1'b0, 1'b0,
			32'h0000_0000);
		dbg_idx_i = 3'h2;
		@(negedge mclk_i);
		check("dbg", dbg_data_o, 32'hA5A5_0001);
	endtask

	// Moves on consecutive edges, the second reading the register the first writes
	task automatic back_to_back();
		req_valid_i = 1'b1;
		op_esc_i = OPC_ESCAPE;
		op_code_i = OPC_MOVE_IF_EQUAL;
		modrm_i = 8'h18;
		mem_data_i = 32'hC3C3_0003;
		flags_i = FLAGS_RESET | (32'h0000_0001 << FLAG_ZF);
		@(negedge mclk_i);
		op_code_i = OPC_MOVE_IF_BELOW;
		modrm_i = 8'hE3;
		mem_data_i = 32'h0000_0000;
		flags_i = FLAGS_RESET | (32'h0000_0001 << FLAG_CF);
		check("b2b_taken_a", 32'(taken_o), 32'h0000_0001);
		check("b2b_dst_a", 32'(dst_idx_o), 32'h0000_0003);
		@(negedge mclk_i);
		req_valid_i = 1'b0;
		check("b2b_done_b", 32'(done_o), 32'h0000_0001);
		check("b2b_taken_b", 32'(taken_o), 32'h0000_0001);
		check("b2b_wr_en_a", 32'(wr_en_o), 32'h0000_0001);
		check("b2b_wr_idx_a", 32'(wr_idx_o), 32'h0000_0003);
		check("b2b_wr_data_a", wr_data_o, 32'hC3C3_0003);
		@(negedge mclk_i);
		check("b2b_wr_en_b", 32'(wr_en_o), 32'h0000_0001);
		check("b2b_wr_idx_b", 32'(wr_idx_o), 32'h0000_0004);
		check("b2b_wr_data_b", wr_data_o, 32'hC3C3_0003);
	endtask

	// Reset in mid-run clears what a finished move left, but not the register file
	task automatic reset_mid();
		run_op(OPC_ESCAPE, OPC_MOVE_IF_NOT_EQUAL, 4'h0, 8'h28, 32'h7E7E_0005, 1'b1, 1'b0,
			32'h7E7E_0005);
		rst_i = 1'b1;
		@(negedge mclk_i);
		check("done_mid", 32'(done_o), 32'h0000_0000);
		check("taken_mid", 32'(taken_o), 32'h0000_0000);
		check("flags_mid", flags_o, FLAGS_RESET);
		check("dst_mid", 32'(dst_idx_o), 32'h0000_0000);
		check("wr_en_mid", 32'(wr_en_o), 32'h0000_0000);
		check("wr_idx_mid", 32'(wr_idx_o), 32'h0000_0000);
		check("wr_data_mid", wr_data_o, DATA_RESET);
		rst_i = 1'b0;
		dbg_idx_i = 3'h5;
		@(negedge mclk_i);
		check("dbg_kept", dbg_data_o, 32'h7E7E_0005);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(negedge mclk_i);
		rst_i = 1'b0;
		check("flags_rst", flags_o, FLAGS_RESET);
		check("done_rst", 32'(done_o), 32'h0000_0000);
		sweep(OPC_MOVE_IF_ABOVE);
		sweep(OPC_MOVE_IF_BELOW_OR_EQUAL);
		sweep(OPC_MOVE_IF_ABOVE_OR_EQUAL);
		sweep(OPC_MOVE_IF_BELOW);
		sweep(OPC_MOVE_IF_EQUAL);
		sweep(OPC_MOVE_IF_NOT_EQUAL);
		sweep(OPC_MOVE_IF_GREATER);
		reg_source();
		back_to_back();
		reset_mid();
		// Neighbouring opcode and a wrong escape byte both stay out of the group
		run_op(OPC_ESCAPE, 8'h40, 4'h2, 8'h18, 32'h1111_1111, 1'b0, 1'b1, 32'h0000_0000);
		run_op(8'h0E, OPC_MOVE_IF_EQUAL, 4'h2, 8'h18, 32'h1111_1111, 1'b0, 1'b1,
			32'h0000_0000);
		close_out();
	end

	// Guards against a hung run
	initial begin
		repeat (20000) @(posedge mclk_i);
		errors++;
		close_out();
	end
endmodule
`default_nettype wire
